/* File: design/pmrs_consts.vh */
`ifndef PMRS_CONSTS_VH
`define PMRS_CONSTS_VH

// ----------------------------------------
// Register byte addresses, one 16-bit register each
// ----------------------------------------
`define PMRS_IDX_PIN26      32'h50003052
`define PMRS_IDX_PIN27      32'h50003054
`define PMRS_IDX_PIN28      32'h50003056
`define PMRS_IDX_PIN29      32'h50003058
`define PMRS_IDX_STATUS     32'h50003060
`define PMRS_IDX_RAIL01     32'h50003070
`define PMRS_IDX_RAIL2      32'h50003072

// ----------------------------------------
// Pin mode register fields
// ----------------------------------------
`define PMRS_DIR_MSB        9
`define PMRS_DIR_LSB        8
`define PMRS_FUNC_MSB       4
`define PMRS_FUNC_LSB       0
`define PMRS_DIR_IN_NONE    2'h0
`define PMRS_DIR_IN_UP      2'h1
`define PMRS_DIR_IN_DOWN    2'h2
`define PMRS_DIR_OUT        2'h3
`define PMRS_MODE_RST       16'h0200
`define PMRS_MODE_MASK      16'h031f
`define PMRS_ANALOG_FUNC    5'h01

// ----------------------------------------
// Rail select register fields
// ----------------------------------------
`define PMRS_RAIL_RST       16'h0000
`define PMRS_RAIL01_MASK    16'h3fff
`define PMRS_RAIL2_MASK     16'h03ff
`define PMRS_P0_MSB         7
`define PMRS_P1_MSB         13
`define PMRS_P1_LSB         8
`define PMRS_P2_MSB         9

`endif

/* File: design/pmrs_mode_reg.v */
`timescale 1ns/1ps
`include "pmrs_consts.vh"

// ----------------------------------------
// One pin mode register, byte-lane writable
// ----------------------------------------
module pmrs_mode_reg (
	// Clock and reset
	input  wire        clk_in,
	input  wire        rst_in,
	// Write port
	input  wire        wr_en_in,
	input  wire [1:0]  sel_in,
	input  wire [15:0] wdat_in,
	// Stored value
	output reg  [15:0] mode_out
);

	wire [15:0] lane_mask;

	// Lane enables gated by the writable field mask
	assign lane_mask = {{8{sel_in[1]}}, {8{sel_in[0]}}} & `PMRS_MODE_MASK; // see (RL10)

	// Storage; reserved bits never leave zero
	always @(posedge clk_in) begin
		if (rst_in) begin
			mode_out <= `PMRS_MODE_RST; // see (RL4)
		end else if (wr_en_in) begin
			mode_out <= (mode_out & ~lane_mask) | (wdat_in & lane_mask); // see (RL3)
		end
	end

endmodule // pmrs_mode_reg

/* File: design/pmrs_pad_decode.v */
`timescale 1ns/1ps
`include "pmrs_consts.vh"

// ----------------------------------------
// Mode word to pad controls, registered
// ----------------------------------------
module pmrs_pad_decode #(
	parameter [4:0] ANALOG_FUNC = `PMRS_ANALOG_FUNC
) (
	// Clock and reset
	input  wire        clk_in,
	input  wire        rst_in,
	// Mode word
	input  wire [15:0] mode_in,
	// Pad controls
	output reg         out_en_out,
	output reg         pull_up_out,
	output reg         pull_down_out,
	output reg  [4:0]  func_out,
	output reg         analog_out
);

	wire [1:0] dir;
	wire [4:0] func;
	wire       analog;

	// Field split
	assign dir    = mode_in[`PMRS_DIR_MSB:`PMRS_DIR_LSB];
	assign func   = mode_in[`PMRS_FUNC_MSB:`PMRS_FUNC_LSB];
	assign analog = (func == ANALOG_FUNC);

	// Analog pins drop drive and resistors whatever dir says
	always @(posedge clk_in) begin
		if (rst_in) begin
			out_en_out    <= 1'b0;
			pull_up_out   <= 1'b0;
			pull_down_out <= 1'b1; // see (RL4)
			func_out      <= 5'h00;
			analog_out    <= 1'b0;
		end else begin
			out_en_out    <= ~analog & (dir == `PMRS_DIR_OUT);     // see (RL1) (RL2)
			pull_up_out   <= ~analog & (dir == `PMRS_DIR_IN_UP);   // see (RL1) (RL2)
			pull_down_out <= ~analog & (dir == `PMRS_DIR_IN_DOWN); // see (RL1) (RL2)
			func_out      <= func; // see (RL3)
			analog_out    <= analog;
		end
	end

endmodule // pmrs_pad_decode

/* File: design/pmrs_top.v */
`timescale 1ns/1ps
`include "pmrs_consts.vh"

// Behaviour
// (RL1) Dir/pull field 9:8: 00 in, 01 pull-up, 10 pull-down, 11 output.
// (RL2) In analog mode the dir/pull field has no effect on the pad.
// (RL3) Each pin mode register holds a five-bit function code at 4:0.
// (RL4) Mode registers reset to dir/pull 2 and function code 0.
// (RL5) Rail register 0/1 bits 13:8 select port-1 pins 0 to 5.
// (RL6) Rail register 0/1 low bits select port-0 pins, bit 0 is pin 0.
// (RL7) Port-2 rail register bits 9:0 select port-2 pins 0 to 9.
// (RL8) Rail bit one means 1V rail, zero 3V rail; all reset zero.
// (RL9) Software picks 3V rail for buck mode, 1V for boost mode.
// (RL10) Reserved bits read zero and ignore writes.
module pmrs_top #(
	parameter       NPINS       = 4,
	parameter [4:0] ANALOG_FUNC = `PMRS_ANALOG_FUNC
) (
	// Clock and reset
	input  wire                 clk_in,
	input  wire                 rst_in,
	// Wishbone slave
	input  wire                 wb_cyc_in,
	input  wire                 wb_stb_in,
	input  wire                 wb_we_in,
	input  wire [31:0]          wb_adr_in,
	input  wire [3:0]           wb_sel_in,
	input  wire [31:0]          wb_dat_in,
	output reg  [31:0]          wb_dat_out,
	output reg                  wb_ack_out,
	output reg                  wb_err_out,
	// Port-2 pin pad controls, pin 26 in bit 0
	output wire [NPINS-1:0]     pad_out_en_out,
	output wire [NPINS-1:0]     pad_pull_up_out,
	output wire [NPINS-1:0]     pad_pull_down_out,
	output wire [NPINS*5-1:0]   pad_func_out,
	output wire [NPINS-1:0]     pad_analog_out,
	// Output rail selects, one = 1V rail
	output wire [7:0]           port0_rail_1v_out,
	output wire [5:0]           port1_rail_1v_out,
	output wire [9:0]           port2_rail_1v_out
);

	// ----------------------------------------
	// Address decode helpers
	// ----------------------------------------

	// Byte address against a register address
	// Full compare, so no register shows up at an alias
	function hit;
		input [31:0] adr;
		input [31:0] idx;
		begin
			hit = (adr == idx);
		end
	endfunction

	// Byte lane enables spread over a 16-bit word
	function [15:0] lanes;
		input [1:0] sel;
		begin
			lanes = {{8{sel[1]}}, {8{sel[0]}}};
		end
	endfunction

	// Byte lanes merged into a 16-bit register
	// Reserved bits are masked out, so they never leave zero
	function [15:0] merge;
		input [15:0] old;
		input [15:0] wdat;
		input [1:0]  sel;
		input [15:0] mask;
		reg   [15:0] m;
		begin
			m     = lanes(sel) & mask;
			merge = (old & ~m) | (wdat & m);
		end
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------

	// Bus answer states
	localparam [1:0] ST_IDLE = 2'b00; // Waiting for a request
	localparam [1:0] ST_ACK  = 2'b01; // Mapped place, ack high
	localparam [1:0] ST_ERR  = 2'b10; // Unmapped place, err high

	// Writable bits of the rail registers; the rest are reserved
	localparam [15:0] RAIL01_WMASK = `PMRS_RAIL01_MASK;
	localparam [15:0] RAIL2_WMASK  = `PMRS_RAIL2_MASK;

	// Rail select storage and next values
	reg  [15:0]         rail01_reg;
	reg  [15:0]         rail2_reg;
	reg  [15:0]         rail01_next;
	reg  [15:0]         rail2_next;

	// Bus answer state
	reg  [1:0]          state_reg;
	reg  [1:0]          state_next;

	// Decode results for the address on the bus
	reg  [31:0]         rdat_next;
	reg                 mapped_next;
	reg  [NPINS-1:0]    mode_sel_next;

	// Selects of the single registers
	reg                 rail01_sel_next;
	reg                 rail2_sel_next;
	reg                 status_sel_next;

	// Request qualifiers and write enables
	wire                req;
	wire                first;
	wire                wr_stb;
	wire [NPINS-1:0]    mode_wr;
	wire                rail01_wr;
	wire                rail2_wr;

	// Mode words, address table, status view
	wire [NPINS*16-1:0] mode_bus;
	wire [NPINS*32-1:0] mode_idx;
	wire [15:0]         status_word;

	// Bus request seen; only an idle slave takes a fresh one
	// Gating on the state, not on ack, keeps err to one cycle
	assign req   = wb_cyc_in & wb_stb_in;
	assign first = req & (state_reg == ST_IDLE);

	// Writes land on the edge the master samples ack; err never writes
	assign wr_stb = req & (state_reg == ST_ACK) & wb_we_in;

	// Per-register write strobes from the shared decode
	assign mode_wr   = {NPINS{wr_stb}} & mode_sel_next;
	assign rail01_wr = wr_stb & rail01_sel_next;
	assign rail2_wr  = wr_stb & rail2_sel_next;

	// Address table of the pin mode registers
	// Pin 29 takes the next halfword after pin 28
	assign mode_idx = {`PMRS_IDX_PIN29, `PMRS_IDX_PIN28,
	                   `PMRS_IDX_PIN27, `PMRS_IDX_PIN26};

	// ----------------------------------------
	// Pin mode registers and pad decode
	// ----------------------------------------

	genvar g;
	generate
		for (g = 0; g < NPINS; g = g + 1) begin : g_pin
			// Stored mode word
			pmrs_mode_reg u_mode (
				.clk_in   (clk_in),
				.rst_in   (rst_in),
				.wr_en_in (mode_wr[g]),
				.sel_in   (wb_sel_in[1:0]),
				.wdat_in  (wb_dat_in[15:0]),
				.mode_out (mode_bus[g*16 +: 16])
			);

			// Pad controls follow the mode one cycle later
			pmrs_pad_decode #(
				.ANALOG_FUNC (ANALOG_FUNC)
			) u_dec (
				.clk_in        (clk_in),
				.rst_in        (rst_in),
				.mode_in       (mode_bus[g*16 +: 16]),
				.out_en_out    (pad_out_en_out[g]),
				.pull_up_out   (pad_pull_up_out[g]),
				.pull_down_out (pad_pull_down_out[g]),
				.func_out      (pad_func_out[g*5 +: 5]),
				.analog_out    (pad_analog_out[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Status word from the live pad state
	// ----------------------------------------

	// Read-only view of what the pads are actually doing
	// Layout: out_en, pull-up, pull-down, analog, four bits each
	// Absent pins read zero, so the bit layout never moves
	genvar s;
	generate
		for (s = 0; s < 4; s = s + 1) begin : g_stat
			if (s < NPINS) begin : g_used
				assign status_word[s]      = pad_out_en_out[s];
				assign status_word[4 + s]  = pad_pull_up_out[s];
				assign status_word[8 + s]  = pad_pull_down_out[s];
				assign status_word[12 + s] = pad_analog_out[s];
			end else begin : g_none
				assign status_word[s]      = 1'b0;
				assign status_word[4 + s]  = 1'b0;
				assign status_word[8 + s]  = 1'b0;
				assign status_word[12 + s] = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------
	// Decode of the bus address
	// ----------------------------------------

	// One decode serves the read mux, the writes and the answer
	// mapped_next chooses between ack and err
	integer i;
	always @* begin
		mode_sel_next = {NPINS{1'b0}};
		for (i = 0; i < NPINS; i = i + 1) begin
			if (hit(wb_adr_in, mode_idx[i*32 +: 32])) begin
				mode_sel_next[i] = 1'b1;
			end
		end
		// Single registers
		rail01_sel_next = hit(wb_adr_in, `PMRS_IDX_RAIL01);
		rail2_sel_next  = hit(wb_adr_in, `PMRS_IDX_RAIL2);
		status_sel_next = hit(wb_adr_in, `PMRS_IDX_STATUS);
		mapped_next     = (|mode_sel_next) | rail01_sel_next | rail2_sel_next | status_sel_next;
	end

	// ----------------------------------------
	// Read mux and next rail values
	// ----------------------------------------

	// Read mux; reserved bits and unmapped places read zero
	// The decode is one-hot, so the order of the tests is free
	integer j;
	always @* begin
		rdat_next = 32'h00000000;
		for (j = 0; j < NPINS; j = j + 1) begin
			if (mode_sel_next[j]) begin
				rdat_next = {16'h0000, mode_bus[j*16 +: 16]}; // see (RL10)
			end
		end
		if (rail01_sel_next) begin
			rdat_next = {16'h0000, rail01_reg};
		end
		if (rail2_sel_next) begin
			rdat_next = {16'h0000, rail2_reg};
		end
		if (status_sel_next) begin
			rdat_next = {16'h0000, status_word};
		end
	end

	// Lane merge for the port 0/1 rails
	always @* begin
		rail01_next = rail01_reg;
		if (rail01_sel_next) begin
			rail01_next = merge(rail01_reg, wb_dat_in[15:0], wb_sel_in[1:0],
			                    RAIL01_WMASK); // see (RL5) (RL6) (RL10)
		end
	end

	// Lane merge for the port-2 rails
	always @* begin
		rail2_next = rail2_reg;
		if (rail2_sel_next) begin
			rail2_next = merge(rail2_reg, wb_dat_in[15:0], wb_sel_in[1:0],
			                   RAIL2_WMASK); // see (RL7) (RL10)
		end
	end

	// ----------------------------------------
	// Rail select registers
	// ----------------------------------------

	// Port 0/1 rails, written only on the acknowledged edge
	// Reset puts every pin on the 3V rail
	always @(posedge clk_in) begin
		if (rst_in) begin
			rail01_reg <= `PMRS_RAIL_RST; // see (RL8)
		end else if (rail01_wr) begin
			rail01_reg <= rail01_next;
		end
	end

	// Port-2 rails, untouched by writes elsewhere
	always @(posedge clk_in) begin
		if (rst_in) begin
			rail2_reg <= `PMRS_RAIL_RST; // see (RL8)
		end else if (rail2_wr) begin
			rail2_reg <= rail2_next;
		end
	end

	// Port-0 pin n from bit n; one selects the 1V rail
	assign port0_rail_1v_out = rail01_reg[`PMRS_P0_MSB:0];                // see (RL6) (RL8)

	// Port-1 pins 0 to 5 from bits 13:8
	assign port1_rail_1v_out = rail01_reg[`PMRS_P1_MSB:`PMRS_P1_LSB];     // see (RL5) (RL8)

	// Port-2 pin n from bit n
	assign port2_rail_1v_out = rail2_reg[`PMRS_P2_MSB:0];                 // see (RL7) (RL8)

	// ----------------------------------------
	// Wishbone handshake
	// ----------------------------------------

	// Next answer state; each request gets exactly one answer cycle
	// A master that keeps cyc up after ack starts a fresh request
	always @* begin
		case (state_reg)
			ST_IDLE: begin
				if (first & mapped_next) begin
					state_next = ST_ACK;
				end else if (first) begin
					state_next = ST_ERR;
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_ACK: begin
				state_next = ST_IDLE;
			end
			ST_ERR: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Answer registered from the next state, so outputs come from flops
	always @(posedge clk_in) begin
		if (rst_in) begin
			state_reg  <= ST_IDLE;
			wb_ack_out <= 1'b0;
			wb_err_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			// State and flags move together
			state_reg  <= state_next;
			wb_ack_out <= (state_next == ST_ACK);
			wb_err_out <= (state_next == ST_ERR);
			// Read data stands only with ack, zero otherwise
			if ((state_next == ST_ACK) & ~wb_we_in) begin
				wb_dat_out <= rdat_next;
			end else begin
				wb_dat_out <= 32'h00000000;
			end
		end
	end

endmodule // pmrs_top

/* File: tb/pmrs_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Bus and pad properties
// ----------------------------------------
module pmrs_properties #(
	parameter       NPINS       = 4,
	parameter [4:0] ANALOG_FUNC = 5'h01
) (
	// Clock and reset
	input wire               clk_in,
	input wire               rst_in,
	// Bus
	input wire               wb_cyc_in,
	input wire               wb_stb_in,
	input wire [31:0]        wb_dat_out,
	input wire               wb_ack_out,
	input wire               wb_err_out,
	// Pads and rails
	input wire [NPINS-1:0]   pad_out_en_out,
	input wire [NPINS-1:0]   pad_pull_up_out,
	input wire [NPINS-1:0]   pad_pull_down_out,
	input wire [NPINS*5-1:0] pad_func_out,
	input wire [NPINS-1:0]   pad_analog_out,
	input wire [7:0]         port0_rail_1v_out,
	input wire [5:0]         port1_rail_1v_out,
	input wire [9:0]         port2_rail_1v_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Request seen while no answer pending
	sequence s_req;
		wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
	endsequence
	sequence s_answer;
		(wb_ack_out ^ wb_err_out) ##1 (!wb_ack_out && !wb_err_out);
	endsequence
	a_req_answered: assert property (s_req |=> s_answer) else $error("request not answered in one cycle");
	a_data_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("read data not zero");
	a_ack_err_excl: assert property (!(wb_ack_out && wb_err_out)) else $error("ack and err together");
	// Reset values seen on the first edge after release
	a_reset_pads: assert property ($fell(rst_in) |-> pad_pull_down_out == {NPINS{1'b1}}
		&& pad_out_en_out == 0 && pad_func_out == 0) else $error("pad reset state wrong");
	a_reset_rails: assert property ($fell(rst_in) |-> {port2_rail_1v_out, port1_rail_1v_out,
		port0_rail_1v_out} == 24'h0) else $error("rail reset state wrong");
	a_pad_one_mode: assert property (((pad_out_en_out & pad_pull_up_out) | (pad_pull_up_out &
		pad_pull_down_out) | (pad_out_en_out & pad_pull_down_out)) == 0) else $error("pad modes overlap");
	a_analog_no_drive: assert property ((pad_analog_out & (pad_out_en_out | pad_pull_up_out |
		pad_pull_down_out)) == 0) else $error("analog pin still driven");
	a_analog_from_func: assert property (pad_analog_out[0] == (pad_func_out[4:0] == ANALOG_FUNC))
		else $error("analog flag does not follow function");
endmodule // pmrs_properties

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "pmrs_consts.vh"

module tb_top;
	localparam [4:0]  AF  = 5'h01;
	localparam [31:0] M26 = `PMRS_IDX_PIN26;
	localparam [31:0] M27 = `PMRS_IDX_PIN27;
	localparam [31:0] M28 = `PMRS_IDX_PIN28;
	localparam [31:0] M29 = `PMRS_IDX_PIN29;
	localparam [31:0] R01 = `PMRS_IDX_RAIL01;
	localparam [31:0] R2  = `PMRS_IDX_RAIL2;
	localparam [31:0] ST  = `PMRS_IDX_STATUS;
	reg         clk_in    = 1'b0;
	reg         rst_in    = 1'b1;
	reg         wb_cyc_in = 1'b0;
	reg         wb_stb_in = 1'b0;
	reg         wb_we_in  = 1'b0;
	reg  [31:0] wb_adr_in = 32'h0;
	reg  [3:0]  wb_sel_in = 4'h0;
	reg  [31:0] wb_dat_in = 32'h0;
	wire [31:0] wb_dat_out;
	wire        wb_ack_out, wb_err_out;
	wire [3:0]  oe, pu, pd, an;
	wire [19:0] fn;
	wire [7:0]  r0;
	wire [5:0]  r1;
	wire [9:0]  r2;
	integer     error_cnt = 0;
	integer     checked = 0;
	integer     i;
	reg  [31:0] rd;
	reg         e;

	pmrs_top #(.NPINS(4), .ANALOG_FUNC(AF)) pmrs_top_i (.clk_in(clk_in), .rst_in(rst_in),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
		.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.wb_err_out(wb_err_out), .pad_out_en_out(oe), .pad_pull_up_out(pu), .pad_pull_down_out(pd),
		.pad_func_out(fn), .pad_analog_out(an), .port0_rail_1v_out(r0), .port1_rail_1v_out(r1),
		.port2_rail_1v_out(r2));

	// 100 ns period
	always #50 clk_in = ~clk_in;

	task stop_test;
		begin
			$display("checked %0d error_cnt %0d", checked, error_cnt);
			if (error_cnt == 0 && checked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	task chk(input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("Error at %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// One classic cycle; held until ack or err is sampled
	task xfer(input w, input [31:0] a, input [3:0] s, input [31:0] d);
		begin
			@(posedge clk_in);
			{wb_cyc_in, wb_stb_in, wb_we_in} <= {2'b11, w};
			{wb_adr_in, wb_sel_in, wb_dat_in} <= {a, s, d};
			@(posedge clk_in);
			while (wb_ack_out !== 1'b1 && wb_err_out !== 1'b1)
				@(posedge clk_in);
			rd = wb_dat_out;
			e = wb_err_out;
			{wb_cyc_in, wb_stb_in, wb_we_in} <= 3'b000;
			#1;
		end
	endtask

	// Pad controls lag the register by one edge
	task settle;
		begin
			repeat (2) @(posedge clk_in);
			#1;
		end
	endtask

	// Watchdog at 4000 cycles, far beyond the roughly 110 cycles needed
	initial begin
		#400000;
		error_cnt = error_cnt + 1;
		$display("Error at %0t got %h expected %h", $time, 1'b0, 1'b1);
		stop_test;
	end

	initial begin
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			xfer(1'b0, M26 + 2 * i, 4'h3, 32'h0);
			chk(rd, `PMRS_MODE_RST);
		end
		chk({oe, pu, pd}, 12'h00f);
		xfer(1'b0, R01, 4'h3, 32'h0);
		chk(rd, 32'h0);
		// Every direction and pull code
		for (i = 0; i < 4; i = i + 1) begin
			xfer(1'b1, M26, 4'h3, i << 8);
			settle;
			chk({oe[0], pu[0], pd[0]}, {i == 3, i == 1, i == 2});
		end
		// Reserved bits dropped, full function code kept
		xfer(1'b1, M27, 4'hf, 32'hffffffff);
		xfer(1'b0, M27, 4'h3, 32'h0);
		chk(rd, `PMRS_MODE_MASK);
		chk({fn[9:5], oe[1]}, 6'h3f);
		xfer(1'b1, M28, 4'h3, {22'h0, 2'b11, 3'b000, AF});
		settle;
		chk({an[2], oe[2], fn[14:10]}, {2'b10, AF});
		// Live pad view: pins 26/27 drive, 28 analog, 29 pulled down
		xfer(1'b0, ST, 4'h3, 32'h0);
		chk(rd, 32'h4803);
		// Low lane only
		xfer(1'b1, M29, 4'h1, 32'hffff);
		xfer(1'b0, M29, 4'h3, 32'h0);
		chk(rd, 32'h021f);
		xfer(1'b1, R01, 4'h3, 32'hffff);
		xfer(1'b0, R01, 4'h3, 32'h0);
		chk(rd, `PMRS_RAIL01_MASK);
		xfer(1'b1, R01, 4'h3, 32'h0120);
		chk({r1, r0}, 14'h0120);
		xfer(1'b1, R01, 4'h3, 32'h2001);
		chk({r1, r0}, 14'h2001);
		xfer(1'b1, R2, 4'h3, 32'hffff);
		xfer(1'b0, R2, 4'h3, 32'h0);
		chk(rd, `PMRS_RAIL2_MASK);
		xfer(1'b1, R2, 4'h3, 32'h0201);
		chk(r2, 10'h201);
		// Buck mode setting: every port-2 pin back on the 3V rail
		xfer(1'b1, R2, 4'h3, 32'h0);
		chk(r2, 10'h000);
		// Unmapped place
		xfer(1'b0, 32'h0, 4'h3, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(rd, 32'h0);
		// Second reset in mid-run
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		xfer(1'b0, M27, 4'h3, 32'h0);
		chk(rd, `PMRS_MODE_RST);
		chk({pd, r0}, 12'hf00);
		chk({r2, r1}, 16'h0000);
		stop_test;
	end
endmodule // tb_top

bind pmrs_top pmrs_properties #(.NPINS(NPINS), .ANALOG_FUNC(ANALOG_FUNC)) pmrs_properties_i (
	.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
	.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .wb_err_out(wb_err_out),
	.pad_out_en_out(pad_out_en_out), .pad_pull_up_out(pad_pull_up_out),
	.pad_pull_down_out(pad_pull_down_out), .pad_func_out(pad_func_out), .pad_analog_out(pad_analog_out),
	.port0_rail_1v_out(port0_rail_1v_out), .port1_rail_1v_out(port1_rail_1v_out),
	.port2_rail_1v_out(port2_rail_1v_out));
